// ### common/exec_pkg.sv
// shared types and constants for the execution unit
package exec_pkg;

    // ****************************************
    // widths and constants
    // ****************************************
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int CNT_W = 3;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ALL_ZERO = 8'h00;
    localparam logic [7:0] SIGN_MIN = 8'h80;
    localparam logic [7:0] SIGN_MAX = 8'h7F;
    localparam logic [15:0] PC_STEP_ONE = 16'h0001;
    localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
    localparam logic [15:0] PC_SKIP_TWO = 16'h0003;
    localparam logic [15:0] PC_STEP_TWO = 16'h0002;

    // ****************************************
    // cycle counts
    // ****************************************
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_THREE = 3'h3;
    localparam logic [2:0] CYC_FOUR = 3'h4;

    // ****************************************
    // status flag bit positions
    // ****************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [5:0] {
        op_sum, op_sum_carry, op_word_sum_imm,
        op_difference_reg, op_difference_const,
        op_difference_with_borrow, op_difference_const_borrow,
        op_word_difference_imm,
        op_conj_regs, op_conj_const, op_disj_regs, op_disj_const, op_xor_regs,
        op_bitwise_invert, op_arith_invert, op_set_mask_bits, op_clear_mask_bits,
        op_plus_one, op_minus_one, op_zero_sign_check, op_zero_reg, op_all_ones_reg,
        op_product_unsigned, op_product_signed, op_product_mixed,
        op_fraction_product_unsigned, op_fraction_product_signed,
        op_fraction_product_mixed,
        op_relative_jump, op_pointer_jump, op_absolute_jump,
        op_relative_call, op_pointer_call, op_absolute_call,
        op_sub_exit, op_irq_exit,
        op_skip_if_equal, op_compare_regs, op_compare_with_borrow,
        op_compare_immediate,
        op_skip_if_reg_bit_clear, op_skip_if_reg_bit_set,
        op_skip_if_io_bit_clear, op_skip_if_io_bit_set,
        op_branch_flag_set, op_branch_flag_clear, op_branch_same_or_higher,
        op_branch_signed_ge, op_branch_signed_lt
    } op_t;

    typedef struct packed {
        op_t op;
        logic [7:0] a;
        logic [7:0] b;
        logic [15:0] word;
        logic [2:0] bit_sel;
        logic io_bit;
        logic next_two_word;
        logic [15:0] pc;
        logic [15:0] offset;
        logic [15:0] z_ptr;
        logic [15:0] target;
        logic [15:0] stack_word;
    } exec_req_t;

    typedef struct packed {
        logic reg_we;
        logic [7:0] reg_data;
        logic pair_we;
        logic pair_product;
        logic [15:0] pair_data;
        logic pc_we;
        logic [15:0] pc_data;
        logic push_we;
        logic [15:0] push_data;
        logic pop_re;
    } exec_wb_t;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic h;
        logic v;
    } alu8_t;

    typedef struct packed {
        logic [15:0] p;
        logic z;
        logic c;
    } prod_t;

endpackage

// ### core/exec_unit.sv
// execution unit: arithmetic, logic, multiply, jumps, skips and branches
`timescale 1ns/1ps
// Summary of operation
// RULE_01: add registers, one cycle, five flags
// RULE_02: add with carry, one cycle, five flags
// RULE_03: word add immediate, two cycles, five flags
// RULE_04: subtract register or constant, one cycle
// RULE_05: subtract with borrow, one cycle, five flags
// RULE_06: word subtract immediate, two cycles, five flags
// RULE_07: and, or, xor one cycle, Z N V
// RULE_08: one's and two's complement flag sets
// RULE_09: set and clear mask bits, Z N V
// RULE_10: plus or minus one, carry kept
// RULE_11: zero and sign check, Z N V
// RULE_12: zero register flags, all ones none
// RULE_13: multiply into pair one:zero, two cycles
// RULE_14: fractional multiply shifts product left one
// RULE_15: jump timing two, two, three cycles
// RULE_16: calls three or four cycles, flags kept
// RULE_17: returns four cycles, interrupt return sets I
// RULE_18: register skips advance two or three
// RULE_19: compares update flags, store nothing
// RULE_20: I/O bit skips, one to three cycles
// RULE_21: flag branches, one untaken, two taken
// RULE_22: signed branches use N xor V
// RULE_23: unlisted flags keep their value
module exec_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request from decoder
    input wire logic req_valid,
    output logic req_ready,
    input exec_pkg::exec_req_t req,
    // results
    output logic done,
    output exec_pkg::exec_wb_t wb,
    output logic [7:0] status_flags_reg
);
    import exec_pkg::*;

    typedef enum logic {st_idle, st_busy} state_t;

    // ****************************************
    // helpers
    // ****************************************
    function automatic alu8_t addsub8(input logic [7:0] x, input logic [7:0] y,
                                      input logic cin, input logic sub);
        logic [7:0] yy;
        logic [8:0] s;
        logic [4:0] nib;
        logic ci;
        alu8_t r;
        yy = sub ? ~y : y;
        ci = cin ^ sub;
        s = {1'b0, x} + {1'b0, yy} + {8'h00, ci};
        nib = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, ci};
        r.res = s[7:0];
        r.c = sub ? ~s[8] : s[8];
        r.h = sub ? ~nib[4] : nib[4];
        r.v = (x[7] == yy[7]) && (s[7] != x[7]);
        return r;
    endfunction

    function automatic logic [2:0] skip_cycles(input logic hit, input logic two);
        return hit ? (two ? CYC_THREE : CYC_TWO) : CYC_ONE;
    endfunction

    function automatic logic [15:0] skip_pc(input logic [15:0] pc, input logic two);
        return pc + (two ? PC_SKIP_TWO : PC_SKIP_ONE);
    endfunction

    // ****************************************
    // operand decode
    // ****************************************
    wire op_t op = req.op;
    wire logic [7:0] fl = status_flags_reg;
    wire logic carry_in = fl[FLAG_C];
    wire logic borrow_op = (op == op_difference_with_borrow)
                         || (op == op_difference_const_borrow)
                         || (op == op_compare_with_borrow);
    wire logic sub_op = borrow_op || (op == op_difference_reg) || (op == op_difference_const)
                      || (op == op_compare_regs) || (op == op_compare_immediate);
    wire logic arith_cin = (op == op_sum_carry) ? carry_in : (borrow_op & carry_in);
    wire alu8_t arith = addsub8(req.a, req.b, arith_cin, sub_op);
    wire alu8_t negate = addsub8(ALL_ZERO, req.a, 1'b0, 1'b1);
    wire logic [15:0] word_k = {10'h000, req.b[5:0]};
    wire logic [16:0] word_sum = {1'b0, req.word} + {1'b0, word_k};
    wire logic [16:0] word_diff = {1'b0, req.word} - {1'b0, word_k};
    wire logic word_sub = (op == op_word_difference_imm);
    wire logic [15:0] word_res = word_sub ? word_diff[15:0] : word_sum[15:0];
    wire logic word_c = word_sub ? word_diff[16] : word_sum[16];
    wire logic word_v = word_sub ? (req.word[15] & ~word_res[15])
                                 : (~req.word[15] & word_res[15]);
    wire logic [7:0] plus_res = req.a + 8'h01;
    wire logic [7:0] minus_res = req.a - 8'h01;
    wire logic mul_a_signed = (op == op_product_signed) || (op == op_product_mixed)
                            || (op == op_fraction_product_signed)
                            || (op == op_fraction_product_mixed);
    wire logic mul_b_signed = (op == op_product_signed)
                            || (op == op_fraction_product_signed);
    wire logic mul_frac = (op == op_fraction_product_unsigned)
                        || (op == op_fraction_product_signed)
                        || (op == op_fraction_product_mixed);
    wire logic is_mul = mul_frac || mul_a_signed || (op == op_product_unsigned);

    // ****************************************
    // skip and branch conditions
    // ****************************************
    wire logic reg_bit = req.a[req.bit_sel];
    wire logic sel_flag = fl[req.bit_sel];
    wire logic signed_lt = fl[FLAG_N] ^ fl[FLAG_V];
    wire logic [15:0] rel_target = req.pc + req.offset + PC_STEP_ONE;
    logic skip_hit;
    logic br_taken;

    always_comb begin
        skip_hit = 1'b0;
        br_taken = 1'b0;
        case (op)
            op_skip_if_equal: skip_hit = (req.a == req.b); // RULE_18
            op_skip_if_reg_bit_clear: skip_hit = ~reg_bit; // RULE_18
            op_skip_if_reg_bit_set: skip_hit = reg_bit; // RULE_18
            op_skip_if_io_bit_clear: skip_hit = ~req.io_bit; // RULE_20
            op_skip_if_io_bit_set: skip_hit = req.io_bit; // RULE_20
            op_branch_flag_set: br_taken = sel_flag; // RULE_21
            op_branch_flag_clear: br_taken = ~sel_flag; // RULE_21
            op_branch_same_or_higher: br_taken = ~fl[FLAG_C]; // RULE_21
            op_branch_signed_ge: br_taken = ~signed_lt; // RULE_22
            op_branch_signed_lt: br_taken = signed_lt; // RULE_22
            default: br_taken = 1'b0;
        endcase
    end

    // ****************************************
    // result, flags and cycle count
    // ****************************************
    exec_wb_t next_wb;
    logic [7:0] next_flags;
    logic [2:0] cycles;
    logic [7:0] lres;

    always_comb begin
        next_wb = '0;
        next_flags = fl; // RULE_23
        cycles = CYC_ONE;
        lres = ALL_ZERO;
        case (op)
            op_sum, op_sum_carry, op_difference_reg, op_difference_const,
            op_difference_with_borrow, op_difference_const_borrow: begin
                next_wb.reg_we = 1'b1; // RULE_01 RULE_02 RULE_04 RULE_05
                next_wb.reg_data = arith.res;
                next_flags[FLAG_C] = arith.c;
                next_flags[FLAG_H] = arith.h;
                next_flags[FLAG_V] = arith.v;
                next_flags[FLAG_N] = arith.res[7];
                next_flags[FLAG_Z] = (arith.res == ALL_ZERO)
                                   & (~borrow_op | fl[FLAG_Z]); // RULE_05
            end
            op_compare_regs, op_compare_with_borrow, op_compare_immediate: begin
                next_flags[FLAG_C] = arith.c; // RULE_19
                next_flags[FLAG_H] = arith.h;
                next_flags[FLAG_V] = arith.v;
                next_flags[FLAG_N] = arith.res[7];
                next_flags[FLAG_Z] = (arith.res == ALL_ZERO) & (~borrow_op | fl[FLAG_Z]);
            end
            op_word_sum_imm, op_word_difference_imm: begin
                cycles = CYC_TWO; // RULE_03 RULE_06
                next_wb.pair_we = 1'b1;
                next_wb.pair_data = word_res;
                next_flags[FLAG_C] = word_c;
                next_flags[FLAG_V] = word_v;
                next_flags[FLAG_N] = word_res[15];
                next_flags[FLAG_Z] = (word_res == 16'h0000);
                next_flags[FLAG_S] = word_res[15] ^ word_v;
            end
            op_conj_regs, op_conj_const, op_disj_regs, op_disj_const, op_xor_regs,
            op_set_mask_bits, op_clear_mask_bits, op_zero_sign_check, op_zero_reg: begin
                case (op)
                    op_conj_regs, op_conj_const: lres = req.a & req.b; // RULE_07
                    op_disj_regs, op_disj_const: lres = req.a | req.b; // RULE_07
                    op_xor_regs: lres = req.a ^ req.b; // RULE_07
                    op_set_mask_bits: lres = req.a | req.b; // RULE_09
                    op_clear_mask_bits: lres = req.a & (ALL_ONES - req.b); // RULE_09
                    op_zero_sign_check: lres = req.a & req.a; // RULE_11
                    op_zero_reg: lres = req.a ^ req.a; // RULE_12
                    default: lres = ALL_ZERO;
                endcase
                next_wb.reg_we = 1'b1;
                next_wb.reg_data = lres;
                next_flags[FLAG_V] = 1'b0;
                next_flags[FLAG_N] = lres[7];
                next_flags[FLAG_Z] = (lres == ALL_ZERO);
            end
            op_bitwise_invert: begin
                next_wb.reg_we = 1'b1; // RULE_08
                next_wb.reg_data = ALL_ONES - req.a;
                next_flags[FLAG_C] = 1'b1;
                next_flags[FLAG_V] = 1'b0;
                next_flags[FLAG_N] = ~req.a[7];
                next_flags[FLAG_Z] = (req.a == ALL_ONES);
            end
            op_arith_invert: begin
                next_wb.reg_we = 1'b1; // RULE_08
                next_wb.reg_data = negate.res;
                next_flags[FLAG_C] = negate.c;
                next_flags[FLAG_H] = negate.h;
                next_flags[FLAG_V] = negate.v;
                next_flags[FLAG_N] = negate.res[7];
                next_flags[FLAG_Z] = (negate.res == ALL_ZERO);
            end
            op_plus_one: begin
                next_wb.reg_we = 1'b1; // RULE_10
                next_wb.reg_data = plus_res;
                next_flags[FLAG_V] = (plus_res == SIGN_MIN);
                next_flags[FLAG_N] = plus_res[7];
                next_flags[FLAG_Z] = (plus_res == ALL_ZERO);
            end
            op_minus_one: begin
                next_wb.reg_we = 1'b1; // RULE_10
                next_wb.reg_data = minus_res;
                next_flags[FLAG_V] = (minus_res == SIGN_MAX);
                next_flags[FLAG_N] = minus_res[7];
                next_flags[FLAG_Z] = (minus_res == ALL_ZERO);
            end
            op_all_ones_reg: begin
                next_wb.reg_we = 1'b1; // RULE_12
                next_wb.reg_data = ALL_ONES;
            end
            op_product_unsigned, op_product_signed, op_product_mixed,
            op_fraction_product_unsigned, op_fraction_product_signed,
            op_fraction_product_mixed: begin
                cycles = CYC_TWO; // RULE_13 RULE_14
                next_wb.pair_we = 1'b1;
                next_wb.pair_product = 1'b1;
            end
            op_relative_jump: begin
                cycles = CYC_TWO; // RULE_15
                next_wb.pc_we = 1'b1;
                next_wb.pc_data = rel_target;
            end
            op_pointer_jump: begin
                cycles = CYC_TWO; // RULE_15
                next_wb.pc_we = 1'b1;
                next_wb.pc_data = req.z_ptr;
            end
            op_absolute_jump: begin
                cycles = CYC_THREE; // RULE_15
                next_wb.pc_we = 1'b1;
                next_wb.pc_data = req.target;
            end
            op_relative_call, op_pointer_call: begin
                cycles = CYC_THREE; // RULE_16
                next_wb.pc_we = 1'b1;
                next_wb.pc_data = (op == op_pointer_call) ? req.z_ptr : rel_target;
                next_wb.push_we = 1'b1;
                next_wb.push_data = req.pc + PC_STEP_ONE;
            end
            op_absolute_call: begin
                cycles = CYC_FOUR; // RULE_16
                next_wb.pc_we = 1'b1;
                next_wb.pc_data = req.target;
                next_wb.push_we = 1'b1;
                next_wb.push_data = req.pc + PC_STEP_TWO;
            end
            op_sub_exit, op_irq_exit: begin
                cycles = CYC_FOUR; // RULE_17
                next_wb.pc_we = 1'b1;
                next_wb.pc_data = req.stack_word;
                next_wb.pop_re = 1'b1;
                next_flags[FLAG_I] = fl[FLAG_I] | (op == op_irq_exit); // RULE_17
            end
            op_skip_if_equal, op_skip_if_reg_bit_clear, op_skip_if_reg_bit_set,
            op_skip_if_io_bit_clear, op_skip_if_io_bit_set: begin
                cycles = skip_cycles(skip_hit, req.next_two_word); // RULE_18 RULE_20
                next_wb.pc_we = skip_hit;
                next_wb.pc_data = skip_pc(req.pc, req.next_two_word);
            end
            op_branch_flag_set, op_branch_flag_clear, op_branch_same_or_higher,
            op_branch_signed_ge, op_branch_signed_lt: begin
                cycles = br_taken ? CYC_TWO : CYC_ONE; // RULE_21 RULE_22
                next_wb.pc_we = br_taken;
                next_wb.pc_data = rel_target;
            end
            default: next_wb = '0;
        endcase
    end

    // ****************************************
    // sequencing
    // ****************************************
    state_t state;
    logic [CNT_W-1:0] cnt;
    exec_wb_t pend_wb;
    logic [7:0] pend_flags;
    logic pend_mul;
    prod_t prod;

    assign req_ready = (state == st_idle);
    wire logic accept = req_valid & req_ready;
    wire logic commit_now = accept && (cycles == CYC_ONE);
    wire logic commit_late = (state == st_busy) && (cnt == CYC_ONE);

    mul_unit #(
        .WIDTH(DATA_W)
    ) u_mul (
        .clk(clk),
        .rst_n(rst_n),
        .start(accept & is_mul),
        .a(req.a),
        .b(req.b),
        .a_signed(mul_a_signed),
        .b_signed(mul_b_signed),
        .frac(mul_frac),
        .prod(prod)
    );

    exec_wb_t late_wb;
    logic [7:0] late_flags;

    always_comb begin
        late_wb = pend_wb;
        late_flags = pend_flags;
        if (pend_mul) begin
            late_wb.pair_data = prod.p; // RULE_13 RULE_14
            late_flags[FLAG_Z] = prod.z;
            late_flags[FLAG_C] = prod.c;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_idle;
            cnt <= '0;
            pend_wb <= '0;
            pend_flags <= FLAGS_RESET;
            pend_mul <= 1'b0;
        end else if (accept) begin
            state <= commit_now ? st_idle : st_busy;
            cnt <= cycles - CYC_ONE;
            pend_wb <= next_wb;
            pend_flags <= next_flags;
            pend_mul <= is_mul;
        end else if (state == st_busy) begin
            cnt <= cnt - CYC_ONE;
            state <= commit_late ? st_idle : st_busy;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
            wb <= '0;
            status_flags_reg <= FLAGS_RESET;
        end else begin
            done <= commit_now | commit_late;
            wb <= commit_now ? next_wb : (commit_late ? late_wb : '0);
            if (commit_now | commit_late) begin
                status_flags_reg <= commit_now ? next_flags : late_flags;
            end
        end
    end
endmodule

// ### core/mul_unit.sv
// two-cycle multiplier for integer and fractional products
`timescale 1ns/1ps
module mul_unit #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // operands
    input wire logic start,
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic a_signed,
    input wire logic b_signed,
    input wire logic frac,
    // product
    output exec_pkg::prod_t prod
);
    import exec_pkg::*;

    if (WIDTH != DATA_W) begin
        $error("mul_unit: WIDTH must equal DATA_W");
    end

    wire logic signed [WIDTH:0] ext_a = {a_signed & a[WIDTH-1], a};
    wire logic signed [WIDTH:0] ext_b = {b_signed & b[WIDTH-1], b};
    wire logic signed [2*WIDTH+1:0] full = ext_a * ext_b;
    wire logic [15:0] raw = full[15:0];
    wire logic [15:0] shifted = frac ? {raw[14:0], 1'b0} : raw;

    // ****************************************
    // product register
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prod <= '0;
        end else if (start) begin
            prod.p <= shifted;
            prod.z <= (shifted == 16'h0000);
            prod.c <= raw[15];
        end
    end
endmodule

// ### tb/exec_unit_assertions.sv
// assertion checker for the execution unit ports
`timescale 1ns/1ps
module exec_unit_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request
    input wire logic req_valid,
    input wire logic req_ready,
    input exec_pkg::exec_req_t req,
    // results
    input wire logic done,
    input exec_pkg::exec_wb_t wb,
    input wire logic [7:0] status_flags_reg
);
    import exec_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire go = req_valid && req_ready;
    wire [7:0] fl = status_flags_reg;
    // ****************
    // properties
    // ****************
    a_sum_one_cycle: assert property (go && req.op == op_sum |=> done && wb.reg_we &&
        wb.reg_data == $past(req.a) + $past(req.b)) else $error("sum wrong");
    a_mul_two_cycles: assert property (go && req.op == op_product_unsigned |=>
        !req_ready && !done ##1 done && wb.pair_product &&
        wb.pair_data == $past(req.a, 2) * $past(req.b, 2)) else $error("product wrong");
    a_jump_three_cycles: assert property (go && req.op == op_absolute_jump |=>
        !done [*2] ##1 done && wb.pc_we && wb.pc_data == $past(req.target, 3))
        else $error("jump wrong");
    a_call_keeps_flags: assert property (go && req.op == op_absolute_call |->
        ##4 done && wb.push_data == $past(req.pc, 4) + 16'h0002 && fl == $past(fl, 4))
        else $error("call wrong");
    a_flags_hold: assert property (!done |-> $stable(fl)) else $error("flags moved");
    a_ones_keep_flags: assert property (go && req.op == op_all_ones_reg |=>
        done && wb.reg_data == 8'hFF && fl == $past(fl)) else $error("all ones wrong");
    a_branch_lt_taken: assert property (go && req.op == op_branch_signed_lt &&
        (fl[FLAG_N] ^ fl[FLAG_V]) |=> !done ##1 done &&
        wb.pc_data == $past(req.pc, 2) + $past(req.offset, 2) + 16'h0001) else $error("branch");
    a_skip_two_words: assert property (go && req.op == op_skip_if_reg_bit_clear &&
        !req.a[req.bit_sel] && req.next_two_word |=> !done [*2] ##1 done &&
        wb.pc_data == $past(req.pc, 3) + 16'h0003) else $error("skip wrong");
endmodule
bind exec_unit exec_unit_checker chk_u (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .done(done), .wb(wb), .status_flags_reg(status_flags_reg));

// ### tb/tb.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
module tb;
    import exec_pkg::*;
    typedef struct {op_t op; logic [7:0] a; logic [7:0] b; logic [7:0] c;
        logic [15:0] d; logic [7:0] f;} row_t;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic req_valid = 1'h0;
    logic req_ready;
    logic done;
    exec_req_t req = '0;
    exec_wb_t wb;
    logic [7:0] status_flags_reg;
    int failures = 0;
    int samples_checked = 0;
    // c: cycles in high nibble, write kind in low (1 reg, 2 pair, 3 pc)
    row_t rows [$] = '{
    '{op_sum,8'h0F,8'h01,8'h11,16'h0010,8'h20}, '{op_sum_carry,8'h80,8'h80,8'h11,16'h0000,8'h0B},
    '{op_difference_reg,8'h00,8'h01,8'h11,16'h00FF,8'h25},
    '{op_minus_one,8'h80,8'h00,8'h11,16'h007F,8'h29},
    '{op_branch_signed_ge,8'h00,8'h00,8'h10,16'h0000,8'h29},
    '{op_branch_signed_lt,8'h00,8'h00,8'h23,16'h0111,8'h29},
    '{op_branch_flag_set,8'h00,8'h05,8'h23,16'h0111,8'h29},
    '{op_branch_same_or_higher,8'h00,8'h00,8'h10,16'h0000,8'h29},
    '{op_difference_with_borrow,8'h05,8'h04,8'h11,16'h0000,8'h00},
    '{op_branch_flag_clear,8'h00,8'h01,8'h23,16'h0111,8'h00},
    '{op_plus_one,8'h7F,8'h00,8'h11,16'h0080,8'h0C}, '{op_conj_regs,8'hF0,8'h0F,8'h11,16'h0000,8'h02},
    '{op_xor_regs,8'h80,8'h01,8'h11,16'h0081,8'h04},
    '{op_bitwise_invert,8'h0F,8'h00,8'h11,16'h00F0,8'h05},
    '{op_arith_invert,8'h01,8'h00,8'h11,16'h00FF,8'h25},
    '{op_clear_mask_bits,8'hFF,8'h0F,8'h11,16'h00F0,8'h25},
    '{op_set_mask_bits,8'h00,8'h00,8'h11,16'h0000,8'h23},
    '{op_zero_reg,8'h55,8'h00,8'h11,16'h0000,8'h23},
    '{op_all_ones_reg,8'h00,8'h00,8'h11,16'h00FF,8'h23},
    '{op_zero_sign_check,8'h80,8'h00,8'h11,16'h0080,8'h25},
    '{op_compare_immediate,8'h10,8'h20,8'h10,16'h0000,8'h05},
    '{op_disj_regs,8'h01,8'h02,8'h11,16'h0003,8'h01},
    '{op_difference_const,8'h10,8'h01,8'h11,16'h000F,8'h20},
    '{op_difference_const_borrow,8'h10,8'h10,8'h11,16'h0000,8'h00},
    '{op_compare_regs,8'h33,8'h33,8'h10,16'h0000,8'h02},
    '{op_compare_with_borrow,8'h33,8'h33,8'h10,16'h0000,8'h02},
    '{op_conj_const,8'hFF,8'h80,8'h11,16'h0080,8'h04}, '{op_disj_const,8'h00,8'h00,8'h11,16'h0000,8'h02},
    '{op_word_sum_imm,8'hFF,8'h01,8'h22,16'h0000,8'h03},
    '{op_word_difference_imm,8'h00,8'h01,8'h22,16'hFFFF,8'h15},
    '{op_product_unsigned,8'hFF,8'hFF,8'h22,16'hFE01,8'h15},
    '{op_product_signed,8'hFF,8'hFF,8'h22,16'h0001,8'h14},
    '{op_product_mixed,8'hFF,8'h02,8'h22,16'hFFFE,8'h15},
    '{op_fraction_product_unsigned,8'h80,8'h80,8'h22,16'h8000,8'h14},
    '{op_fraction_product_signed,8'h40,8'h40,8'h22,16'h2000,8'h14},
    '{op_fraction_product_mixed,8'h80,8'h80,8'h22,16'h8000,8'h15},
    '{op_skip_if_equal,8'h05,8'h05,8'h23,16'h0102,8'h15},
    '{op_skip_if_reg_bit_clear,8'h00,8'h40,8'h33,16'h0103,8'h15},
    '{op_skip_if_reg_bit_set,8'h00,8'h00,8'h10,16'h0000,8'h15},
    '{op_skip_if_io_bit_set,8'h00,8'h80,8'h23,16'h0102,8'h15},
    '{op_skip_if_io_bit_clear,8'h00,8'h40,8'h33,16'h0103,8'h15},
    '{op_relative_jump,8'h00,8'h00,8'h23,16'h0111,8'h15},
    '{op_pointer_jump,8'h00,8'h00,8'h23,16'h0200,8'h15},
    '{op_absolute_jump,8'h00,8'h00,8'h33,16'h0300,8'h15},
    '{op_relative_call,8'h00,8'h00,8'h33,16'h0111,8'h15},
    '{op_pointer_call,8'h00,8'h00,8'h33,16'h0200,8'h15},
    '{op_absolute_call,8'h00,8'h00,8'h43,16'h0300,8'h15},
    '{op_sub_exit,8'h00,8'h00,8'h43,16'h0400,8'h15}, '{op_irq_exit,8'h00,8'h00,8'h43,16'h0400,8'h95}};
    exec_unit dut_u (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .done(done), .wb(wb), .status_flags_reg(status_flags_reg));
    always #4 clk = ~clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        report_and_stop();
    end
    initial begin
        int n;
        req.pc = 16'h0100;
        req.offset = 16'h0010;
        req.z_ptr = 16'h0200;
        req.target = 16'h0300;
        req.stack_word = 16'h0400;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        chk(16'(status_flags_reg), 16'h0000);
        foreach (rows[i]) begin
            @(posedge clk);
            req.op <= rows[i].op;
            req.a <= rows[i].a;
            req.b <= rows[i].b;
            req.word <= {rows[i].a, rows[i].a};
            req.bit_sel <= rows[i].b[2:0];
            req.io_bit <= rows[i].b[7];
            req.next_two_word <= rows[i].b[6];
            req_valid <= 1'h1;
            @(posedge clk);
            req_valid <= 1'h0;
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (done !== 1'h1 && n < 8);
            chk(16'(n), 16'(rows[i].c[7:4]));
            chk(16'(wb.reg_we), 16'(rows[i].c[1:0] == 2'h1));
            chk(16'({wb.pair_we, wb.pc_we}), 16'(2'(4'h8 >> rows[i].c[1:0])));
            case (rows[i].c[1:0])
                2'h1: chk(16'(wb.reg_data), rows[i].d);
                2'h2: chk(wb.pair_data, rows[i].d);
                2'h3: chk(wb.pc_data, rows[i].d);
                default: ;
            endcase
            chk(16'(status_flags_reg), 16'(rows[i].f));
        end
        @(posedge clk);
        req.op <= op_sum;
        req.a <= 8'h01;
        req.b <= 8'h01;
        req_valid <= 1'h1;
        @(posedge clk);
        req.a <= 8'h02;
        @(negedge clk);
        chk(16'(wb.reg_data), 16'h0002);
        @(posedge clk);
        req_valid <= 1'h0;
        @(negedge clk);
        chk(16'(wb.reg_data), 16'h0003);
        @(posedge clk);
        rst_n <= 1'h0;
        @(negedge clk);
        chk(16'(status_flags_reg), 16'h0000);
        chk(16'(req_ready), 16'h0001);
        report_and_stop();
    end
endmodule
